// ### hw/dram_ctl_pkg.sv
// constants for the fast-page dram controller: pin widths, timings, state codes
// assumes a 10 MHz ref_clk; every time below but the row cycle time is turned into whole clock cycles
package dram_ctl_pkg;
  localparam int CLK_PERIOD_NS  = 100;
  localparam int ADDR_W         = 10;
  localparam int DATA_W         = 16;
  localparam int ROW_W          = 10;
  localparam int COL_W          = 10;
  localparam int ROWS           = 1024;
  // power-up pause and wake-up sequence
  localparam int WAKE_PAUSE_US  = 200;
  localparam int WAKE_PAUSE_CYC = (WAKE_PAUSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_REFRESHES = 8;
  // refresh period for all rows, longest time so rounded down per row
  localparam int REFRESH_MS     = 16;
  localparam int REFRESH_ROW_CYC = (REFRESH_MS * 1000000 / CLK_PERIOD_NS) / ROWS;
  // strobe timings, least times rounded up
  localparam int RAS_CYCLE_NS   = 84;
  localparam int RAS_PULSE_NS   = 50;
  localparam int RAS_PRE_NS     = 30;
  localparam int CAS_PRE_NS     = 9;
  localparam int CAS_PULSE_NS   = 8;
  localparam int CAS_SETUP_NS   = 5;
  localparam int CAS_HOLD_NS    = 8;
  localparam int RAS_PULSE_CYC  = (RAS_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAS_PRE_CYC    = (RAS_PRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAS_PRE_CYC    = (CAS_PRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAS_PULSE_CYC  = (CAS_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAS_SETUP_CYC  = (CAS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAS_HOLD_CYC   = (CAS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_CNT_W      = 12;
  localparam int WAKE_CNT_W     = 12;
  localparam logic [1:0] BYTE_BOTH = 2'h3;

  // sequencer states, gray codes along the read/write path from idle to precharge
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_ROW     = 4'h1,
    ST_COL     = 4'h3,
    ST_DATA    = 4'h2,
    ST_PRE     = 4'h6,
    ST_REF_COL = 4'h7,
    ST_REF_ROW = 4'h5,
    ST_REF_END = 4'h4,
    ST_WAKE    = 4'hC
  } seq_state_t;
endpackage

// ### hw/dram_wait_timer.sv
// down-counting delay timer used for the wake-up pause; strobe spacing comes from the sequencer states
// assumes load and enable share ref_clk; done is high while the count is zero
`timescale 1ns/100ps
module dram_wait_timer (
  // clock and reset
  input  wire logic                               ref_clk,
  input  wire logic                               rst_n,
  input  wire logic                               clk_en,
  // control
  input  wire logic                               load,
  input  wire logic [dram_ctl_pkg::CYC_CNT_W-1:0] load_val,
  output      logic                               done
);
  logic [dram_ctl_pkg::CYC_CNT_W-1:0] count;

  // load wins over the running count so back-to-back waits chain cleanly
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (clk_en) begin
      if (load) begin
        count <= load_val;
      end else if (count != '0) begin
        count <= count - 1'b1;
      end
    end
  end

  assign done = (count == '0);
endmodule

// ### hw/dram_refresh_sched.sv
// refresh scheduler: paces one refresh per row slot, tracks overdue refresh
// assumes the sequencer acknowledges each request with a one-cycle done pulse
`timescale 1ns/100ps
module dram_refresh_sched (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // handshake with sequencer
  input  wire logic running,
  input  wire logic refresh_done,
  output      logic refresh_req,
  output      logic refresh_overdue
);
  logic [dram_ctl_pkg::CYC_CNT_W-1:0] slot_cnt;
  logic [1:0]                         pending;
  wire                                slot_tick = (slot_cnt == '0);

  // slot counter spreads all rows evenly across the refresh period
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_cnt <= '0;
    end else if (clk_en && running) begin
      slot_cnt <= slot_tick ? dram_ctl_pkg::CYC_CNT_W'(dram_ctl_pkg::REFRESH_ROW_CYC - 1)
                            : slot_cnt - 1'b1;
    end
  end

  // pending refreshes; a second missed slot means the period slipped
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending         <= 2'h0;
      refresh_overdue <= 1'b0;
    end else if (clk_en && running) begin
      if (slot_tick && !refresh_done && pending == 2'h2) begin
        refresh_overdue <= 1'b1;
      end else if (refresh_done && !slot_tick) begin
        refresh_overdue <= 1'b0;
      end
      if (slot_tick && !refresh_done && pending != 2'h2) begin
        pending <= pending + 2'h1;
      end else if (refresh_done && !slot_tick && pending != 2'h0) begin
        pending <= pending - 2'h1;
      end
    end else if (clk_en) begin
      pending         <= 2'h0;
      refresh_overdue <= 1'b0;
    end
  end

  assign refresh_req = (pending != 2'h0);
endmodule

// ### hw/dram_fpm_host.sv
// host-side sequencer for an asynchronous 1M x 16 fast-page dram
// assumes the dram pins are wired straight out; data pin tristate is resolved by the bench
`timescale 1ns/100ps
module dram_fpm_host (
  // clock, reset, freeze
  input  wire logic                                 ref_clk,
  input  wire logic                                 rst_n,
  input  wire logic                                 clk_en,
  // user request port
  input  wire logic                                 req_valid,
  input  wire logic                                 req_write,
  input  wire logic [1:0]                           req_bytes,
  input  wire logic [dram_ctl_pkg::ROW_W-1:0]       req_row,
  input  wire logic [dram_ctl_pkg::COL_W-1:0]       req_col,
  input  wire logic [dram_ctl_pkg::DATA_W-1:0]      req_wdata,
  output      logic                                 req_ready,
  output      logic                                 rd_valid,
  output      logic [dram_ctl_pkg::DATA_W-1:0]      rd_data,
  output      logic                                 init_done,
  // dram pins
  output      logic                                 row_strobe_n,
  output      logic                                 lower_byte_col_strobe_n,
  output      logic                                 upper_byte_col_strobe_n,
  output      logic                                 write_strobe_n,
  output      logic                                 out_gate_n,
  output      logic [dram_ctl_pkg::ADDR_W-1:0]      dram_addr,
  input  wire logic [dram_ctl_pkg::DATA_W-1:0]      dq_in,
  output      logic [dram_ctl_pkg::DATA_W-1:0]      dq_out,
  output      logic [1:0]                           dq_oe
);

  // short local names for the sequencer states
  localparam dram_ctl_pkg::seq_state_t S_IDLE    = dram_ctl_pkg::ST_IDLE;
  localparam dram_ctl_pkg::seq_state_t S_ROW     = dram_ctl_pkg::ST_ROW;
  localparam dram_ctl_pkg::seq_state_t S_COL     = dram_ctl_pkg::ST_COL;
  localparam dram_ctl_pkg::seq_state_t S_DATA    = dram_ctl_pkg::ST_DATA;
  localparam dram_ctl_pkg::seq_state_t S_PRE     = dram_ctl_pkg::ST_PRE;
  localparam dram_ctl_pkg::seq_state_t S_REF_COL = dram_ctl_pkg::ST_REF_COL;
  localparam dram_ctl_pkg::seq_state_t S_REF_ROW = dram_ctl_pkg::ST_REF_ROW;
  localparam dram_ctl_pkg::seq_state_t S_REF_END = dram_ctl_pkg::ST_REF_END;
  localparam dram_ctl_pkg::seq_state_t S_WAKE    = dram_ctl_pkg::ST_WAKE;

  // counts sized to the counters that load or compare them
  localparam logic [dram_ctl_pkg::CYC_CNT_W-1:0]  PAUSE_CYCLES  =
    dram_ctl_pkg::CYC_CNT_W'(dram_ctl_pkg::WAKE_PAUSE_CYC);
  localparam logic [dram_ctl_pkg::WAKE_CNT_W-1:0] WAKE_LAST_CNT =
    dram_ctl_pkg::WAKE_CNT_W'(dram_ctl_pkg::WAKE_REFRESHES - 1);

  // sequencer state
  dram_ctl_pkg::seq_state_t               state;
  dram_ctl_pkg::seq_state_t               next_state;

  // request held for the whole memory cycle
  logic                                   cur_write;
  logic [1:0]                             cur_bytes;
  logic [dram_ctl_pkg::COL_W-1:0]         cur_col;

  // wake-up bookkeeping
  logic                                   pause_started;
  logic                                   pause_load;
  logic                                   pause_done;
  logic [dram_ctl_pkg::WAKE_CNT_W-1:0]    wake_cnt;
  logic                                   wake_step;
  logic                                   wake_last;
  logic                                   relaunch;

  // refresh scheduler handshake
  logic                                   refresh_req;
  logic                                   refresh_overdue;
  logic                                   refresh_done;

  // request acceptance and read capture
  logic                                   take_req;
  logic                                   read_end;

  // next values of the registered dram pins
  logic                                   next_row_strobe_n;
  logic                                   next_lower_byte_col_strobe_n;
  logic                                   next_upper_byte_col_strobe_n;
  logic                                   next_write_strobe_n;
  logic                                   next_out_gate_n;
  logic [dram_ctl_pkg::ADDR_W-1:0]        next_dram_addr;
  logic [1:0]                             next_dq_oe;

  // states that hold the row strobe low; one column per open row, no page mode
  function automatic logic row_low(input dram_ctl_pkg::seq_state_t st);
    return (st == S_ROW) || (st == S_COL) || (st == S_DATA)
        || (st == S_REF_ROW) || (st == S_REF_END);
  endfunction

  // states that pull a column strobe low; lane_on picks the byte lane
  function automatic logic col_low(input dram_ctl_pkg::seq_state_t st,
                                   input logic                     lane_on);
    return ((st == S_DATA) && lane_on)
        || (st == S_REF_COL) || (st == S_REF_ROW);
  endfunction

  // states in which write strobe and write data stand for an early write
  function automatic logic write_window(input dram_ctl_pkg::seq_state_t st);
    return (st == S_COL) || (st == S_DATA);
  endfunction

  // a request is taken only in idle, after wake-up, with no refresh due
  assign req_ready = clk_en && (state == S_IDLE) && init_done && !refresh_req && !refresh_overdue;
  assign take_req  = req_valid && req_ready;
  assign read_end  = (state == S_DATA) && !cur_write;

  // wake-up: pause once after reset, then eight refreshes before access
  assign pause_load = (state == S_WAKE) && !pause_started;
  assign wake_step  = (state == S_REF_END) && !init_done;
  assign wake_last  = (wake_cnt == WAKE_LAST_CNT);

  // a slipped refresh period relaunches the eight-refresh wake-up
  assign relaunch     = (state == S_IDLE) && init_done && refresh_overdue;
  // only refreshes after wake-up count against the row slots
  assign refresh_done = (state == S_REF_END) && init_done;

  // wake pause timer; the pause is far longer than any other wait
  dram_wait_timer u_dram_wait_timer (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .load     (pause_load),
    .load_val (PAUSE_CYCLES),
    .done     (pause_done)
  );

  // refresh pacing across the whole row space
  dram_refresh_sched u_dram_refresh_sched (
    .ref_clk         (ref_clk),
    .rst_n           (rst_n),
    .clk_en          (clk_en),
    .running         (init_done),
    .refresh_done    (refresh_done),
    .refresh_req     (refresh_req),
    .refresh_overdue (refresh_overdue)
  );

  // next state: a due refresh wins over a waiting request in idle
  always_comb begin
    next_state = state;
    case (state)
      S_WAKE: begin
        if (pause_started && pause_done) begin
          next_state = S_IDLE;
        end
      end
      S_IDLE: begin
        if (!init_done || refresh_req || refresh_overdue) begin
          next_state = S_REF_COL;
        end else if (take_req) begin
          next_state = S_ROW;
        end
      end
      S_ROW: begin
        next_state = S_COL;
      end
      S_COL: begin
        next_state = S_DATA;
      end
      S_DATA: begin
        next_state = S_PRE;
      end
      S_REF_COL: begin
        next_state = S_REF_ROW;
      end
      S_REF_ROW: begin
        next_state = S_REF_END;
      end
      S_REF_END: begin
        next_state = S_PRE;
      end
      S_PRE: begin
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_PRE;
      end
    endcase
  end

  // one path through a cycle: row, column, data, precharge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_WAKE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // request latch; write data goes from this flop straight to the pins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_write <= 1'b0;
      cur_bytes <= 2'h0;
      cur_col   <= '0;
      dq_out    <= '0;
    end else if (clk_en && take_req) begin
      cur_write <= req_write;
      cur_bytes <= req_bytes;
      cur_col   <= req_col;
      dq_out    <= req_wdata;
    end
  end

  // wake and relaunch bookkeeping; relaunch clears the count before stepping
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pause_started <= 1'b0;
      wake_cnt      <= '0;
      init_done     <= 1'b0;
    end else if (clk_en) begin
      if (pause_load) begin
        pause_started <= 1'b1;
      end
      if (relaunch) begin
        wake_cnt  <= '0;
        init_done <= 1'b0;
      end else if (wake_step) begin
        wake_cnt  <= wake_cnt + 1'b1;
        init_done <= wake_last;
      end
    end
  end

  // pin decode; pins change only on the clock edge, so no glitch reaches the dram
  assign next_row_strobe_n            = !row_low(next_state);
  assign next_lower_byte_col_strobe_n = !col_low(next_state, cur_bytes[0]);
  assign next_upper_byte_col_strobe_n = !col_low(next_state, cur_bytes[1]);
  // write strobe falls a cycle ahead of the column strobes
  assign next_write_strobe_n = !(write_window(next_state) && cur_write);
  // late write, read-write and gate-controlled writes never arise
  // gate low only in a read, with the write strobe high
  assign next_out_gate_n = !((next_state == S_DATA) && !cur_write);
  // write lanes open with the write strobe, before the column strobes
  assign next_dq_oe = (write_window(next_state) && cur_write) ? cur_bytes : 2'h0;
  // row address with the take, column address a cycle before the column strobes
  assign next_dram_addr = take_req ? req_row
                        : (next_state == S_COL) ? cur_col : dram_addr;

  // dram pin flops; reset parks every strobe high so the dram stays in standby
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      row_strobe_n            <= 1'b1;
      lower_byte_col_strobe_n <= 1'b1;
      upper_byte_col_strobe_n <= 1'b1;
      write_strobe_n          <= 1'b1;
      out_gate_n              <= 1'b1;
      dram_addr               <= '0;
      dq_oe                   <= 2'h0;
    end else if (clk_en) begin
      row_strobe_n            <= next_row_strobe_n;
      lower_byte_col_strobe_n <= next_lower_byte_col_strobe_n;
      upper_byte_col_strobe_n <= next_upper_byte_col_strobe_n;
      write_strobe_n          <= next_write_strobe_n;
      out_gate_n              <= next_out_gate_n;
      dram_addr               <= next_dram_addr;
      dq_oe                   <= next_dq_oe;
    end
  end

  // read data taken at the end of the data cycle, a full period after the column strobes fell
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else if (clk_en) begin
      rd_valid <= read_end;
      if (read_end) begin
        rd_data <= dq_in;
      end
    end
  end

  // hidden refresh is never used: refresh waits for idle instead
  // precharge with every strobe high closes each cycle, clearing held output

  a_ref_col_setup: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($fell(row_strobe_n) && !lower_byte_col_strobe_n)
      |-> ($past(!lower_byte_col_strobe_n) && write_strobe_n))
    else $error("column strobe not set up before refresh row strobe");

  a_early_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($fell(lower_byte_col_strobe_n) && !write_strobe_n)
      |-> $past(!write_strobe_n))
    else $error("write strobe fell after the column strobe");

  a_read_write_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !out_gate_n
      |-> write_strobe_n)
    else $error("write strobe low while output gate open");

  a_gate_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (|dq_oe)
      |-> out_gate_n)
    else $error("output gate open while write data driven");

  a_row_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(row_strobe_n)
      |=> !row_strobe_n)
    else $error("row strobe pulse too short");

  a_row_precharge: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(row_strobe_n)
      |-> (lower_byte_col_strobe_n && upper_byte_col_strobe_n) ##1 row_strobe_n)
    else $error("precharge too short or column strobe still low");

  a_wake_order: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($fell(row_strobe_n) && !init_done)
      |-> !lower_byte_col_strobe_n)
    else $error("access row strobe before wake-up finished");

  a_data_setup: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($fell(lower_byte_col_strobe_n) && !write_strobe_n)
      |-> (dq_oe[0] && $stable(dq_out)))
    else $error("write data not set up at column strobe");
endmodule

// ### tb/dram_fpm_model.sv
// behavioural fast-page dram: row and column latch, byte-lane writes, gated read drive
// assumes strobes come from the host; the bench resolves the shared data lanes
`timescale 1ns/100ps
module dram_fpm_model (
  // strobes
  input  wire logic        row_n,
  input  wire logic        lcol_n,
  input  wire logic        ucol_n,
  input  wire logic        wr_n,
  input  wire logic        gate_n,
  // address and data
  input  wire logic [9:0]  addr,
  input  wire logic [15:0] dq_w,
  output      logic [15:0] dq_r,
  output      logic [1:0]  dq_drv
);
  logic [15:0] mem [0:1048575];
  logic [9:0]  row;
  logic [9:0]  col;
  logic        cf_ref = 1'b0;
  int          ras_cnt = 0;
  // column strobe low at row fall: counter refresh, address pins ignored
  always @(negedge row_n) begin
    #1;
    ras_cnt++;
    cf_ref = !(lcol_n && ucol_n);
    if (!cf_ref) row = addr;
  end
  // the 1 ns waits let same-edge pin updates land first
  always @(negedge lcol_n or negedge ucol_n) #1 if (!row_n) col = addr;
  // write lands at the later fall of column or write strobe, per lane
  always @(negedge lcol_n or negedge ucol_n or negedge wr_n) #1 if (!row_n && !wr_n && !cf_ref) begin
    if (!lcol_n) mem[{row, col}][7:0] = dq_w[7:0];
    if (!ucol_n) mem[{row, col}][15:8] = dq_w[15:8];
  end
  // a lane drives only in a read with row, its column strobe and gate low
  assign dq_drv = (row_n || cf_ref || !wr_n || gate_n) ? 2'h0 : {!ucol_n, !lcol_n};
  assign dq_r   = mem[{row, col}];
endmodule

// ### tb/dram_fpm_host_tb.sv
// self-checking bench: host sequencer against the behavioural dram
// assumes a 10 MHz ref_clk and the package timing constants
`timescale 1ns/100ps
module dram_fpm_host_tb;
  logic        ref_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0, ph = 1'b0;
  logic [1:0]  req_bytes = 2'h3, dq_oe, drv;
  logic [9:0]  req_row = 10'h000, req_col = 10'h000, dram_addr;
  logic [15:0] req_wdata = 16'h0000, rd_data, dq_out, dq_in, dq_r, q;
  logic        req_ready, rd_valid, init_done, row_strobe_n, lower_byte_col_strobe_n;
  logic        upper_byte_col_strobe_n, write_strobe_n, out_gate_n;
  int          fail_count = 0, samples_checked = 0;
  realtime     last_ras = -1000.0;
  always #50 ref_clk = !ref_clk;
  // released lanes show a pattern that flips every cycle, never a held value
  always @(posedge ref_clk) ph <= !ph;
  for (genvar i = 0; i < 2; i++) begin : g_lane
    assign dq_in[i*8+:8] = dq_oe[i] ? dq_out[i*8+:8] : drv[i] ? dq_r[i*8+:8] : {8{ph}} ^ 8'hA5;
  end
  dram_fpm_host u_dram_fpm_host (.ref_clk, .rst_n, .clk_en(1'b1), .req_valid, .req_write,
    .req_bytes, .req_row, .req_col, .req_wdata, .req_ready, .rd_valid, .rd_data, .init_done,
    .row_strobe_n, .lower_byte_col_strobe_n, .upper_byte_col_strobe_n, .write_strobe_n,
    .out_gate_n, .dram_addr, .dq_in, .dq_out, .dq_oe);
  dram_fpm_model u_dram_fpm_model (.row_n(row_strobe_n), .lcol_n(lower_byte_col_strobe_n),
    .ucol_n(upper_byte_col_strobe_n), .wr_n(write_strobe_n), .gate_n(out_gate_n),
    .addr(dram_addr), .dq_w(dq_in), .dq_r(dq_r), .dq_drv(drv));
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("Error at %0t ns: %s", $time, msg);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one request held until taken; a read then waits for its data
  task automatic xfer(input logic w, input logic [1:0] b, input logic [9:0] r, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_bytes <= b;
    req_row   <= r;
    req_col   <= r ^ 10'h3FF;
    req_wdata <= d;
    do @(posedge ref_clk); while (req_ready !== 1'b1 && ++n < 300);
    req_valid <= 1'b0;
    chk(n < 300, "request not taken");
    n = 0;
    if (!w) while (rd_valid !== 1'b1 && n++ < 300) @(posedge ref_clk);
    q = rd_data;
  endtask
  task automatic t_init;
    int n;
    n = 0;
    while (init_done !== 1'b1 && n++ < 5000) @(posedge ref_clk);
    chk(n >= dram_ctl_pkg::WAKE_PAUSE_CYC, "ready before wake pause");
    chk(u_dram_fpm_model.ras_cnt >= 8, "too few wake refreshes");
    $display("test init done");
  endtask
  task automatic t_rw;
    xfer(1'b1, 2'h3, 10'h155, 16'hBEEF);
    xfer(1'b1, 2'h1, 10'h2AA, 16'h1234);
    xfer(1'b1, 2'h2, 10'h2AA, 16'h5678);
    xfer(1'b0, 2'h3, 10'h155, 16'h0000);
    chk(q === 16'hBEEF, "word read back");
    xfer(1'b0, 2'h3, 10'h2AA, 16'h0000);
    chk(q === 16'h5634, "byte lanes merged");
    xfer(1'b0, 2'h2, 10'h155, 16'h0000);
    chk(q[15:8] === 8'hBE, "upper byte read");
    $display("test read write done");
  endtask
  task automatic t_refresh;
    int c;
    c = u_dram_fpm_model.ras_cnt;
    repeat (2 * dram_ctl_pkg::REFRESH_ROW_CYC + 100) @(posedge ref_clk);
    chk(u_dram_fpm_model.ras_cnt - c >= 2, "refresh pace");
    $display("test refresh done");
  endtask
  // no lane driven by both sides; row strobe falls spaced apart
  always @(negedge ref_clk) if (rst_n) chk(!(|(dq_oe & drv)), "lane contention");
  always @(negedge row_strobe_n) if (rst_n) begin
    chk($realtime - last_ras >= 84.0, "row strobe spacing");
    last_ras = $realtime;
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_init;
    t_rw;
    t_refresh;
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    end_of_test;
  end
endmodule
